// ===== logic/rbp_defines.vh
`ifndef RBP_DEFINES_VH
`define RBP_DEFINES_VH
// =====================================================================
// Frame layout
`define RBP_FRAME_BYTES        60
`define RBP_QUADLETS           4'hF
`define RBP_MIN_SYNC_QUADLETS  4'h6
// =====================================================================
// Register indexes (byte address is four times the index)
`define RBP_IDX_CTRL           8'h80
`define RBP_IDX_STATUS         8'h85
`define RBP_IDX_NODE_POSITION  8'h87
`define RBP_IDX_NODE_DELAY     8'h8F
`define RBP_IDX_MAX_POSITION   8'h90
`define RBP_IDX_MAX_DELAY      8'h91
`define RBP_IDX_SYNC_BW        8'h96
// =====================================================================
// Control register fields
`define RBP_CTRL_MASTER_BIT    7
`define RBP_CTRL_SYNC_BYP_BIT  3
`define RBP_CTRL_ALL_BYP_BIT   1
`define RBP_CTRL_IRQ_EN_BIT    0
// Status register fields
`define RBP_ST_ALLOC_BIT       0
`define RBP_ST_SBC_VALID_BIT   1
`define RBP_ST_POS_VALID_BIT   2
`define RBP_ST_DELAY_VALID_BIT 3
`define RBP_ST_MAX_VALID_BIT   4
`define RBP_ST_LOCKED_BIT      5
// =====================================================================
// Reset values
`define RBP_RST_BYTE           8'h00
`define RBP_RST_SAC            4'h0
// =====================================================================
// Frame counts after lock, and sync data delay in frames
`define RBP_POS_VALID_FRAMES   4
`define RBP_DELAY_VALID_FRAMES 1024
`define RBP_MAX_VALID_FRAMES   1024
`define RBP_SYNC_DELAY_FRAMES  2'h2
// AXI responses
`define RBP_RESP_OKAY          2'h0
`define RBP_RESP_SLVERR        2'h2
`endif

// ===== logic/rbp_regs.v
// Operation
// - Frame carries 60 bytes in 15 quadlets.
// - Sync count writable only in timing master.
// - Async quadlets equal fifteen minus sync count.
// - Sync byte number is quadlet*4 plus offset.
// - Bandwidth count resets to zero, not valid.
// - Sync count valid only while locked.
// - Node delay zero at master, increments unbypassed.
// - Unbypassed node delays sync data two frames.
// - Bypassed node forwards sync data undelayed.
// - Position zero at master, bypass nodes skip.
// - Max position counts active nodes, 64 reads 00h.
// - Max delay holds total network node delays.
// - Max change sets flag, optional interrupt.
// - Network values refreshed after lock, then valid.
// - Valid after 4, 1024, 1024 frames.
// - Master select makes node timing master.
// - All-bypass bit set makes node active.
`timescale 1ns/1ps
`include "rbp_defines.vh"
`default_nettype none
module rbp_regs #(
    parameter integer CNT_W        = 11,
    parameter integer DELAY_FRAMES = `RBP_DELAY_VALID_FRAMES,
    parameter integer MAX_FRAMES   = `RBP_MAX_VALID_FRAMES
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address and data
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // Incoming frame information from the upstream neighbour
    input  wire        frame_strobe,
    input  wire        locked,
    input  wire [3:0]  rx_sync_quadlets,
    input  wire [7:0]  rx_node_position,
    input  wire [7:0]  rx_node_delay,
    input  wire [7:0]  rx_active_nodes,
    input  wire [7:0]  rx_total_delay,
    // Outgoing frame information to the downstream neighbour
    output wire [3:0]  tx_sync_quadlets,
    output wire [7:0]  tx_node_position,
    output wire [7:0]  tx_node_delay,
    output wire [7:0]  tx_active_nodes,
    output wire [7:0]  tx_total_delay,
    // Bandwidth split and routing controls
    output wire [3:0]  async_quadlets,
    output wire [5:0]  sync_last_byte,
    output wire [1:0]  sync_delay_frames,
    output wire        node_active,
    output wire        timing_master,
    // Allocation change interrupt, active high
    output wire        alloc_irq
);

    // =================================================================
    // Helpers
    // Physical channel number of a byte within a quadlet.
    function [5:0] byte_number;
        input [3:0] quadlet;
        input [1:0] offset;
        begin
            byte_number = {quadlet, offset};
        end
    endfunction

    // =================================================================
    // Register state
    reg        timing_master_select_reg;
    reg        sync_bypass_reg;
    reg        all_bypass_n_reg;
    reg        alloc_change_irq_enable_reg;
    reg        alloc_change_reg;
    reg [3:0]  sac_reg;
    reg [7:0]  node_position_reg;
    reg [7:0]  node_delay_reg;
    reg [7:0]  max_position_reg;
    reg [7:0]  max_delay_reg;
    reg [CNT_W-1:0] lock_frames_reg;
    reg [7:0]  tx_pos_reg;
    reg [7:0]  tx_delay_reg;
    reg [3:0]  async_reg;
    reg [5:0]  last_byte_reg;
    reg        irq_reg;
    // Bus side state
    reg        aw_held_reg;
    reg        w_held_reg;
    reg [7:0]  aw_idx_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;
    reg        bvalid_reg;
    reg [1:0]  bresp_reg;
    reg        rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0]  rresp_reg;

    // =================================================================
    // Frame-side next values
    wire       frame_upd = frame_strobe & locked;
    wire [7:0] own_pos_next = timing_master_select_reg ? `RBP_RST_BYTE :
                              (all_bypass_n_reg ? rx_node_position + 8'h01 : rx_node_position);
    wire [7:0] own_delay_next = timing_master_select_reg ? `RBP_RST_BYTE :
                                (sync_bypass_reg ? rx_node_delay : rx_node_delay + 8'h01);
    wire [5:0] ring_count = rx_node_position[5:0] + 6'h01;
    wire [7:0] max_pos_next = timing_master_select_reg ? {2'h0, ring_count} : rx_active_nodes;
    wire [7:0] max_delay_next = timing_master_select_reg ? rx_node_delay : rx_total_delay;
    wire       pos_valid = lock_frames_reg >= `RBP_POS_VALID_FRAMES;
    wire       delay_valid = lock_frames_reg >= DELAY_FRAMES;
    wire       max_valid = lock_frames_reg >= MAX_FRAMES;
    wire       max_changed = frame_upd & max_valid &
                             ((max_pos_next != max_position_reg) | (max_delay_next != max_delay_reg));

    // =================================================================
    // Bus write decode
    wire       wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire       wr_ctrl = wr_go & (aw_idx_reg == `RBP_IDX_CTRL) & wstrb_reg[0];
    wire       wr_stat = wr_go & (aw_idx_reg == `RBP_IDX_STATUS) & wstrb_reg[0];
    wire       wr_sbc = wr_go & (aw_idx_reg == `RBP_IDX_SYNC_BW) & wstrb_reg[0];
    wire [7:0] status_byte = {2'h0, locked, max_valid, delay_valid, pos_valid,
                              locked & (sac_reg != `RBP_RST_SAC), alloc_change_reg};
    wire [7:0] ctrl_byte = {timing_master_select_reg, 3'h0, sync_bypass_reg, 1'b0,
                            all_bypass_n_reg, alloc_change_irq_enable_reg};

    // Mapped-address check shared by reads and writes.
    function mapped;
        input [7:0] idx;
        begin
            mapped = (idx == `RBP_IDX_CTRL) | (idx == `RBP_IDX_STATUS) |
                     (idx == `RBP_IDX_NODE_POSITION) | (idx == `RBP_IDX_NODE_DELAY) |
                     (idx == `RBP_IDX_MAX_POSITION) | (idx == `RBP_IDX_MAX_DELAY) |
                     (idx == `RBP_IDX_SYNC_BW);
        end
    endfunction

    // =================================================================
    // Read data multiplexer; unused upper bits read as zero.
    reg [7:0] rd_byte;
    always @*
    begin
        case (s_axi_araddr[9:2])
            `RBP_IDX_CTRL:          rd_byte = ctrl_byte;
            `RBP_IDX_STATUS:        rd_byte = status_byte;
            `RBP_IDX_NODE_POSITION: rd_byte = node_position_reg;
            `RBP_IDX_NODE_DELAY:    rd_byte = node_delay_reg;
            `RBP_IDX_MAX_POSITION:  rd_byte = max_position_reg;
            `RBP_IDX_MAX_DELAY:     rd_byte = max_delay_reg;
            `RBP_IDX_SYNC_BW:       rd_byte = {4'h0, sac_reg};
            default:                rd_byte = `RBP_RST_BYTE;
        endcase
    end

    // =================================================================
    // Control bits written by software.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timing_master_select_reg    <= 1'b0;
            sync_bypass_reg             <= 1'b0;
            all_bypass_n_reg            <= 1'b0;
            alloc_change_irq_enable_reg <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            timing_master_select_reg    <= wdata_reg[`RBP_CTRL_MASTER_BIT];
            sync_bypass_reg             <= wdata_reg[`RBP_CTRL_SYNC_BYP_BIT];
            all_bypass_n_reg            <= wdata_reg[`RBP_CTRL_ALL_BYP_BIT];
            alloc_change_irq_enable_reg <= wdata_reg[`RBP_CTRL_IRQ_EN_BIT];
        end
    end

    // Synchronous quadlet count: host-written in the master, frame-loaded in slaves.
    always @(posedge aclk)
    begin
        if (!aresetn)
            sac_reg <= `RBP_RST_SAC;
        else if (timing_master_select_reg)
        begin
            if (wr_sbc)
                sac_reg <= wdata_reg[3:0];
        end
        else if (frame_upd)
            sac_reg <= rx_sync_quadlets;
    end

    // Frames counted since lock; loss of lock restarts the count.
    always @(posedge aclk)
    begin
        if (!aresetn || !locked)
            lock_frames_reg <= {CNT_W{1'b0}};
        else if (frame_strobe && !(&lock_frames_reg))
            lock_frames_reg <= lock_frames_reg + 1'b1;
    end

    // Network values refreshed once per frame while locked.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            node_position_reg <= `RBP_RST_BYTE;
            node_delay_reg    <= `RBP_RST_BYTE;
            max_position_reg  <= `RBP_RST_BYTE;
            max_delay_reg     <= `RBP_RST_BYTE;
            tx_pos_reg        <= `RBP_RST_BYTE;
            tx_delay_reg      <= `RBP_RST_BYTE;
        end
        else if (frame_upd)
        begin
            node_position_reg <= own_pos_next;
            node_delay_reg    <= own_delay_next;
            tx_pos_reg        <= (all_bypass_n_reg || timing_master_select_reg) ? own_pos_next
                                                                              : rx_node_position;
            tx_delay_reg      <= own_delay_next;
            if (max_valid)
            begin
                max_position_reg <= max_pos_next;
                max_delay_reg    <= max_delay_next;
            end
        end
    end

    // Allocation change flag: a new change wins over a clearing write of one.
    always @(posedge aclk)
    begin
        if (!aresetn)
            alloc_change_reg <= 1'b0;
        else if (max_changed)
            alloc_change_reg <= 1'b1;
        else if (wr_stat && wdata_reg[`RBP_ST_ALLOC_BIT])
            alloc_change_reg <= 1'b0;
    end

    // Derived bandwidth split and the registered interrupt line.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            async_reg     <= `RBP_QUADLETS;
            last_byte_reg <= 6'h0;
            irq_reg       <= 1'b0;
        end
        else
        begin
            async_reg     <= `RBP_QUADLETS - sac_reg;
            last_byte_reg <= (sac_reg == `RBP_RST_SAC) ? 6'h0 : byte_number(sac_reg - 4'h1, 2'h3);
            irq_reg       <= (alloc_change_reg | max_changed) & alloc_change_irq_enable_reg;
        end
    end

    // =================================================================
    // AXI4-Lite write channel: address and data taken in either order.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_idx_reg  <= 8'h00;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `RBP_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_reg && !bvalid_reg)
            begin
                aw_held_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && !w_held_reg && !bvalid_reg)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (mapped(aw_idx_reg) && s_axi_awaddr[11:10] == 2'h0) ? `RBP_RESP_OKAY
                                                                                  : `RBP_RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    // AXI4-Lite read channel: data presented one edge after the address.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `RBP_RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_reg)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h000000, rd_byte};
            rresp_reg  <= (mapped(s_axi_araddr[9:2]) && s_axi_araddr[11:10] == 2'h0) ? `RBP_RESP_OKAY
                                                                                     : `RBP_RESP_SLVERR;
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // =================================================================
    // Outputs, all from flip-flops.
    assign s_axi_awready     = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready      = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid      = bvalid_reg;
    assign s_axi_bresp       = bresp_reg;
    assign s_axi_arready     = ~rvalid_reg;
    assign s_axi_rvalid      = rvalid_reg;
    assign s_axi_rdata       = rdata_reg;
    assign s_axi_rresp       = rresp_reg;
    assign tx_sync_quadlets  = sac_reg;
    assign tx_node_position  = tx_pos_reg;
    assign tx_node_delay     = tx_delay_reg;
    assign tx_active_nodes   = max_position_reg;
    assign tx_total_delay    = max_delay_reg;
    assign async_quadlets    = async_reg;
    assign sync_last_byte    = last_byte_reg;
    assign sync_delay_frames = sync_bypass_reg ? 2'h0 : `RBP_SYNC_DELAY_FRAMES;
    assign node_active       = all_bypass_n_reg;
    assign timing_master     = timing_master_select_reg;
    assign alloc_irq         = irq_reg;

endmodule
`default_nettype wire

// ===== verification/rbp_ring_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Upstream ring neighbour
module rbp_ring_model #(
    parameter integer GAP = 6
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Frame contents chosen by the bench
    input  wire logic       lock_en,
    input  wire logic [3:0] set_sync,
    input  wire logic [7:0] set_pos,
    input  wire logic [7:0] set_delay,
    input  wire logic [7:0] set_nodes,
    input  wire logic [7:0] set_total,
    // Frame link into the block
    output logic            frame_strobe,
    output logic            locked,
    output logic [3:0]      rx_sync_quadlets,
    output logic [7:0]      rx_node_position,
    output logic [7:0]      rx_node_delay,
    output logic [7:0]      rx_active_nodes,
    output logic [7:0]      rx_total_delay
);
    integer gap_cnt;

    // The ring keeps framing while unlocked, so strobes arrive with lock low too.
    always @(posedge aclk)
    begin
        if (!aresetn || gap_cnt == GAP - 1)
            gap_cnt <= 0;
        else
            gap_cnt <= gap_cnt + 1;
        frame_strobe <= aresetn && gap_cnt == GAP - 1;
        locked <= aresetn && lock_en;
    end

    // Unlocked fields churn every cycle so that stale values cannot pass for good ones.
    always @(posedge aclk)
    begin
        if (!aresetn)
            {rx_sync_quadlets, rx_node_position, rx_node_delay, rx_active_nodes, rx_total_delay} <= 36'h0;
        else if (lock_en)
            {rx_sync_quadlets, rx_node_position, rx_node_delay, rx_active_nodes, rx_total_delay} <=
                {set_sync, set_pos, set_delay, set_nodes, set_total};
        else
            {rx_sync_quadlets, rx_node_position, rx_node_delay, rx_active_nodes, rx_total_delay} <=
                ~{rx_sync_quadlets, rx_node_position, rx_node_delay, rx_active_nodes, rx_total_delay};
    end
endmodule
`default_nettype wire

// ===== verification/rbp_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks of the bandwidth and position registers
module rbp_regs_asserts #(
    parameter integer CNT_W        = 11,
    parameter integer DELAY_FRAMES = 1024,
    parameter integer MAX_FRAMES   = 1024
) (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Frame link
    input wire logic       frame_strobe,
    input wire logic       locked,
    input wire logic [3:0] rx_sync_quadlets,
    input wire logic [7:0] rx_node_position,
    input wire logic [7:0] rx_node_delay,
    input wire logic [3:0] tx_sync_quadlets,
    input wire logic [7:0] tx_node_position,
    input wire logic [7:0] tx_node_delay,
    // Split and controls
    input wire logic [3:0] async_quadlets,
    input wire logic [5:0] sync_last_byte,
    input wire logic [1:0] sync_delay_frames,
    input wire logic       node_active,
    input wire logic       timing_master,
    // Register bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Steps that start an update or an answer.
    sequence slave_frame;
        frame_strobe && locked && !timing_master;
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_last_byte_map: assert property (
        sync_last_byte == ((async_quadlets == 4'hF) ? 6'h00 : {4'hF - async_quadlets, 2'h0} - 6'h01))
        else $error("Last sync byte disagrees with the split.");
    a_master_zero: assert property (
        frame_strobe && locked && timing_master |=> tx_node_position == 8'h00 && tx_node_delay == 8'h00)
        else $error("Master position or delay is not zero.");
    a_delay_incr: assert property (
        slave_frame ##0 sync_delay_frames == 2'h2 |=> tx_node_delay == $past(rx_node_delay) + 8'h01)
        else $error("Node delay did not step by one.");
    a_delay_bypass: assert property (
        slave_frame ##0 sync_delay_frames == 2'h0 |=> tx_node_delay == $past(rx_node_delay))
        else $error("Bypassed node changed the delay.");
    a_pos_incr: assert property (
        slave_frame ##0 node_active |=> tx_node_position == $past(rx_node_position) + 8'h01)
        else $error("Active node position did not step by one.");
    a_pos_bypass: assert property (
        slave_frame ##0 !node_active |=> tx_node_position == $past(rx_node_position))
        else $error("All-bypass node changed the position.");
    a_slave_copy: assert property (
        slave_frame |=> tx_sync_quadlets == $past(rx_sync_quadlets))
        else $error("Slave did not copy the sync count.");
    a_hold_between: assert property (
        !(frame_strobe && locked) |=> $stable(tx_node_position) && $stable(tx_node_delay))
        else $error("Frame values moved outside a locked frame.");
    a_write_answer: assert property (
        wr_taken |-> ##2 s_axi_bvalid)
        else $error("Write response late.");
    a_read_answer: assert property (
        rd_taken |=> s_axi_rvalid)
        else $error("Read data late.");
    a_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("Read data dropped before taken.");
endmodule

bind rbp_regs rbp_regs_asserts #(.CNT_W(CNT_W), .DELAY_FRAMES(DELAY_FRAMES), .MAX_FRAMES(MAX_FRAMES)) u_chk (.*);
`default_nettype wire

// ===== verification/rbp_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbp_defines.vh"
`define CHK(nm, exp, got) \
    begin \
        num_checks = num_checks + 1; \
        if ((got) !== (exp)) \
        begin \
            fails = fails + 1; \
            $display("CHECK FAILED %s expected %h seen %h", nm, (exp), (got)); \
        end \
    end
// ==========================================
// Register bench with a ring neighbour model
module rbp_regs_tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lock_en;
    logic        awready, wready, bvalid, arready, rvalid, strobe, lck, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb, set_sync, rxs, asq;
    logic [7:0]  set_pos, set_delay, set_nodes, set_total, rxp, rxd, rxn, rxt;
    logic [1:0]  bresp, rresp, rs, sdf;
    logic [5:0]  slb;
    integer      fails, num_checks, cycles;
    logic [7:0]  ro_idx [5] = '{`RBP_IDX_NODE_POSITION, `RBP_IDX_NODE_DELAY, `RBP_IDX_MAX_POSITION,
                                `RBP_IDX_MAX_DELAY, `RBP_IDX_SYNC_BW};

    rbp_regs #(.DELAY_FRAMES(8), .MAX_FRAMES(8)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_strobe(strobe),
        .locked(lck), .rx_sync_quadlets(rxs), .rx_node_position(rxp), .rx_node_delay(rxd),
        .rx_active_nodes(rxn), .rx_total_delay(rxt), .tx_sync_quadlets(), .tx_node_position(),
        .tx_node_delay(), .tx_active_nodes(), .tx_total_delay(), .async_quadlets(asq),
        .sync_last_byte(slb), .sync_delay_frames(sdf), .node_active(), .timing_master(), .alloc_irq(irq));

    rbp_ring_model u_ring (
        .aclk(aclk), .aresetn(aresetn), .lock_en(lock_en), .set_sync(set_sync), .set_pos(set_pos),
        .set_delay(set_delay), .set_nodes(set_nodes), .set_total(set_total), .frame_strobe(strobe),
        .locked(lck), .rx_sync_quadlets(rxs), .rx_node_position(rxp), .rx_node_delay(rxd),
        .rx_active_nodes(rxn), .rx_total_delay(rxt));

    // Free-running 125 MHz clock.
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // A hang ends the run as a failure.
    always @(posedge aclk)
    begin
        cycles = cycles + 1;
        if (cycles == 6000)
        begin
            fails = fails + 1;
            conclude;
        end
    end

    // Write one register; address and data are released as each is taken.
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h000000, val};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok | awready;
            w_ok = w_ok | wready;
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        rs = bresp;
    endtask

    // Read one register into rd and rs.
    task automatic rdr(input logic [7:0] idx);
        @(posedge aclk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask

    // Read and compare data and response.
    task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        rdr(idx);
        `CHK(nm, exp, rd)
        `CHK(nm, `RBP_RESP_OKAY, rs)
    endtask

    // Wait for n frame strobes, then let updates settle.
    task automatic frames(input integer n);
        repeat (n) @(posedge aclk iff strobe);
        repeat (3) @(posedge aclk);
    endtask

    // Print the counts and the verdict, then stop.
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence: reset values, slave, bypass modes, lock loss, master.
    initial
    begin
        fails = 0;
        num_checks = 0;
        cycles = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, lock_en} = 7'h00;
        {awaddr, araddr, wdata} = 56'h0;
        wstrb = 4'h1;
        {set_sync, set_pos, set_delay, set_nodes, set_total} = {4'h9, 8'h02, 8'h03, 8'h07, 8'h05};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ro_idx[i]) rchk("reset value", ro_idx[i], 32'h0);
        `CHK("async after reset", 4'hF, asq)
        rdr(8'h88);
        `CHK("unmapped resp", `RBP_RESP_SLVERR, rs)
        `CHK("unmapped data", 32'h0, rd)
        wr(`RBP_IDX_NODE_POSITION, 8'h55);
        `CHK("read-only write resp", `RBP_RESP_OKAY, rs)
        rchk("read-only position", `RBP_IDX_NODE_POSITION, 32'h0);
        wr(`RBP_IDX_SYNC_BW, 8'h0A);
        rchk("slave sync write", `RBP_IDX_SYNC_BW, 32'h0);
        wr(`RBP_IDX_CTRL, 8'h02);
        lock_en <= 1'b1;
        frames(10);
        rchk("slave sync copy", `RBP_IDX_SYNC_BW, 32'h9);
        `CHK("async split", 4'h6, asq)
        `CHK("last sync byte", 6'h23, slb)
        rchk("slave position", `RBP_IDX_NODE_POSITION, 32'h3);
        rchk("slave delay", `RBP_IDX_NODE_DELAY, 32'h4);
        `CHK("sync delay frames", 2'h2, sdf)
        rchk("slave max position", `RBP_IDX_MAX_POSITION, 32'h7);
        rchk("slave max delay", `RBP_IDX_MAX_DELAY, 32'h5);
        rdr(`RBP_IDX_STATUS);
        `CHK("valid flags", 32'h3E, rd & 32'h3E)
        wr(`RBP_IDX_STATUS, 8'h01);
        rdr(`RBP_IDX_STATUS);
        `CHK("alloc cleared", 1'b0, rd[0])
        set_nodes <= 8'h08;
        frames(2);
        rdr(`RBP_IDX_STATUS);
        `CHK("alloc on change", 1'b1, rd[0])
        `CHK("irq masked", 1'b0, irq)
        wr(`RBP_IDX_CTRL, 8'h03);
        @(posedge aclk);
        `CHK("irq enabled", 1'b1, irq)
        wr(`RBP_IDX_STATUS, 8'h01);
        @(posedge aclk);
        `CHK("irq cleared", 1'b0, irq)
        wr(`RBP_IDX_CTRL, 8'h0A);
        frames(2);
        rchk("bypass delay", `RBP_IDX_NODE_DELAY, 32'h3);
        `CHK("bypass delay frames", 2'h0, sdf)
        wr(`RBP_IDX_CTRL, 8'h08);
        frames(2);
        rchk("all-bypass position", `RBP_IDX_NODE_POSITION, 32'h2);
        lock_en <= 1'b0;
        frames(3);
        rchk("unlocked position", `RBP_IDX_NODE_POSITION, 32'h2);
        rdr(`RBP_IDX_STATUS);
        `CHK("unlocked flags", 32'h0, rd & 32'h22)
        wr(`RBP_IDX_CTRL, 8'h82);
        lock_en <= 1'b1;
        set_pos <= 8'h3F;
        wr(`RBP_IDX_SYNC_BW, 8'h0E);
        rchk("master sync write", `RBP_IDX_SYNC_BW, 32'hE);
        `CHK("master async", 4'h1, asq)
        `CHK("master last byte", 6'h37, slb)
        wr(`RBP_IDX_SYNC_BW, 8'h0F);
        frames(10);
        rchk("master keeps sync", `RBP_IDX_SYNC_BW, 32'hF);
        `CHK("no async left", 4'h0, asq)
        `CHK("full sync range", 6'h3B, slb)
        rchk("master position", `RBP_IDX_NODE_POSITION, 32'h0);
        rchk("master delay", `RBP_IDX_NODE_DELAY, 32'h0);
        rchk("64 nodes", `RBP_IDX_MAX_POSITION, 32'h0);
        rchk("ring delay", `RBP_IDX_MAX_DELAY, 32'h3);
        conclude;
    end
endmodule
`default_nettype wire
